/* verilog/pbs_sram.sv */
/*
  Top of the pipelined burst static memory: strobe decode, burst counter,
  write decode, read pipeline and data pin drive.
  Assumes synchronous inputs are launched on clk; output enable and the two
  static mode pins arrive unsynchronised. The data pins are split into
  input, output and an active-low enable joined outside.
*/
// Notes on behaviour
// - Array of 131,072 words by 36 bits, seventeen-bit registered address.
// - Processor strobe low with selects active starts a read at new address.
// - Pipelined: read data reaches output register one edge after address.
// - Burst step ignored on the processor strobe edge, sampled afterwards.
// - Burst address steps only on step low with both strobes high.
// - Order select high: low bits are start XOR 01, 10, 11.
// - Order select low: low bits count up modulo four from start.
// - Global write low writes every lane regardless of lane inputs.
// - Global write high: only low lanes written, only with gate low.
// - Lane write false with gate or lane high; cycle counts as read.
// - Lane write inputs ignored on the processor strobe edge.
// - Any lane write sampled low turns data drivers off.
// - Write data captured on each edge a decoded internal lane write is true.
// - Write burst steps when lane write and burst step are both low.
// - Controller strobe edge samples write controls; first access may write.
// - Secondary selects: first active high, second active low, sampled.
// - Single-stage select low gives flow-through, one register of latency.
// - Data pins driven only when enabled, output enable low, and reading.
`timescale 1ns/1ps
`default_nettype none
module pbs_sram
  import pbs_pkg::*;
(
  input  wire logic              clk,                 // Bus clock
  input  wire logic              rst_n,               // Async reset, low
  input  wire logic [ADDR_W-1:0] addrIn,              // External address
  input  wire logic [DATA_W-1:0] dqIn,                // Data pins, in
  output logic      [DATA_W-1:0] dqOut,               // Data pins, out
  output logic                   dqOeN,               // Low drives pins
  input  wire logic              processorAddrStrobeN,  // Processor strobe
  input  wire logic              controllerAddrStrobeN, // Controller strobe
  input  wire logic              burstStepN,          // Burst advance
  input  wire logic              globalWriteN,        // Write all lanes
  input  wire logic              byteWriteGateN,      // Lane write gate
  input  wire logic [LANES-1:0]  laneWriteN,          // Per-lane write
  input  wire logic              masterSelectN,       // Master select
  input  wire logic              selectHi,            // Select, high
  input  wire logic              selectLoN,           // Select, low
  input  wire logic              outputEnableN,       // Async output enable
  input  wire logic              countOrderSelect,    // 1 XOR, 0 linear
  input  wire logic              singleStageSelectN   // 0 flow-through
);
  // ************************************************************
  // Decoding helpers
  // ************************************************************
  // Per-lane internal write from the global, gate and lane inputs
  function automatic logic [LANES-1:0] laneWrites(
    input logic             gwN,
    input logic             gateN,
    input logic [LANES-1:0] lnN
  );
    if (!gwN) begin
      laneWrites = LANES_ALL;
    end else if (!gateN) begin
      laneWrites = ~lnN;
    end else begin
      laneWrites = LANES_NONE;
    end
  endfunction

  // Low address bits for a burst position
  function automatic logic [CNT_W-1:0] burstLow(
    input logic [CNT_W-1:0] base,
    input logic [CNT_W-1:0] cnt,
    input logic             interleave
  );
    burstLow = interleave ? (base ^ cnt)
                          : CNT_W'(base + cnt);
  endfunction

  // ************************************************************
  // Synchronisers for asynchronous and static pins
  // ************************************************************
  logic [2:0] syncA_ff;
  logic [2:0] syncB_ff;
  logic       oeActive;
  logic       interleave;
  logic       pipeMode;

  // Two flops each; output enable therefore acts two edges late, a cost
  // of keeping every pin behind the clock in this model
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_ff <= 3'h0;
      syncB_ff <= 3'h0;
    end else begin
      syncA_ff <= {~outputEnableN, countOrderSelect, singleStageSelectN};
      syncB_ff <= syncA_ff;
    end
  end
  assign oeActive   = syncB_ff[2];
  assign interleave = syncB_ff[1];
  assign pipeMode   = syncB_ff[0];

  // ************************************************************
  // Cycle start and select decode
  // ************************************************************
  logic selOk;
  logic startP;
  logic startC;
  logic deselect;
  logic active_ff;
  logic cont;

  assign selOk  = selectHi & ~selectLoN;
  assign startP = ~processorAddrStrobeN & ~masterSelectN & selOk;
  // Controller start needs processor strobe high, ignores master select
  assign startC = ~controllerAddrStrobeN & processorAddrStrobeN
                  & selOk;
  assign deselect = ~startP & ~startC
                  & ((~processorAddrStrobeN & ~masterSelectN)
                  | (~controllerAddrStrobeN & processorAddrStrobeN));
  assign cont = active_ff & ~startP & ~startC & ~deselect;

  // Chip stays selected from a start until a deselecting strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_ff <= 1'b0;
    end else if (startP | startC) begin
      active_ff <= 1'b1;
    end else if (deselect) begin
      active_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Address register and burst counter
  // ************************************************************
  logic [ADDR_W-1:0] addr_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  cntNow;
  logic [ADDR_W-1:0] curAddr;
  logic              step;

  // Both strobes high and step low; strobe edges never step
  assign step = cont & ~burstStepN & processorAddrStrobeN
                & controllerAddrStrobeN;

  // A stepping edge already accesses the next burst position
  assign cntNow = step ? CNT_W'(cnt_ff + CNT_STEP) : cnt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= ADDR_ZERO;
      cnt_ff  <= CNT_ZERO;
    end else if (startP | startC) begin
      addr_ff <= addrIn;
      cnt_ff  <= CNT_ZERO;
    end else if (step) begin
      cnt_ff  <= cntNow;
    end
  end

  // A start edge accesses the new address at once
  assign curAddr = (startP | startC) ? addrIn
                 : {addr_ff[ADDR_W-1:CNT_W],
                    burstLow(addr_ff[CNT_W-1:0], cntNow, interleave)};

  // ************************************************************
  // Write decode and array
  // ************************************************************
  logic [LANES-1:0]  wrLanes;
  logic              readNow;
  logic [DATA_W-1:0] rdData;

  // Processor start edges never write; controller starts may
  assign wrLanes = (startC | cont)
                 ? laneWrites(globalWriteN, byteWriteGateN, laneWriteN)
                 : LANES_NONE;
  assign readNow = startP | ((startC | cont) & (wrLanes == LANES_NONE));

  // Data is taken into the array on the very edge it is sampled
  pbs_store uStore (
    .clk     (clk),
    .wrLanes (wrLanes),
    .wrAddr  (curAddr),
    .wrData  (dqIn),
    .rdAddr  (curAddr),
    .rdData  (rdData)
  );

  // ************************************************************
  // Read pipeline and pin drive
  // ************************************************************
  logic [DATA_W-1:0] stage_ff;
  logic              stageVld_ff;
  logic [DATA_W-1:0] dqOut_ff;
  logic              dqOeN_ff;
  logic              nxt_outVld;
  logic              outVld_ff;

  // Pipelined mode adds the second register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_ff    <= DATA_ZERO;
      stageVld_ff <= 1'b0;
      dqOut_ff    <= DATA_ZERO;
    end else begin
      stage_ff    <= rdData;
      stageVld_ff <= readNow;
      if (pipeMode) begin
        dqOut_ff <= stage_ff;
      end else begin
        dqOut_ff <= rdData;
      end
    end
  end

  assign nxt_outVld = pipeMode ? stageVld_ff : readNow;

  // Drive only valid read data; a sampled lane write wins over enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outVld_ff <= 1'b0;
      dqOeN_ff  <= 1'b1;
    end else begin
      outVld_ff <= nxt_outVld;
      dqOeN_ff  <= ~(nxt_outVld & oeActive)
                   | ~(&laneWriteN);
    end
  end

  assign dqOut = dqOut_ff;
  assign dqOeN = dqOeN_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_startRead;
    @(posedge clk) disable iff (!rst_n)
      startP |=> active_ff && addr_ff == $past(addrIn) && cnt_ff == CNT_ZERO;
  endproperty
  a_startRead: assert property (p_startRead)
    else $error("processor start did not load address");

  property p_pipeLatency;
    @(posedge clk) disable iff (!rst_n)
      (readNow && pipeMode) ##1 pipeMode
        |-> ##1 (dqOut_ff == $past(rdData, 2));
  endproperty
  a_pipeLatency: assert property (p_pipeLatency)
    else $error("pipelined read data not out two edges later");

  property p_flowLatency;
    @(posedge clk) disable iff (!rst_n)
      (readNow && !pipeMode) |=> (dqOut_ff == $past(rdData));
  endproperty
  a_flowLatency: assert property (p_flowLatency)
    else $error("flow-through read data late");

  property p_noStepOnStart;
    @(posedge clk) disable iff (!rst_n)
      (startP && !burstStepN) |=> cnt_ff == CNT_ZERO;
  endproperty
  a_noStepOnStart: assert property (p_noStepOnStart)
    else $error("burst stepped on processor strobe edge");

  property p_stepCount;
    @(posedge clk) disable iff (!rst_n)
      step |=> cnt_ff == CNT_W'($past(cnt_ff) + CNT_STEP);
  endproperty
  a_stepCount: assert property (p_stepCount)
    else $error("burst counter did not step");

  property p_holdCount;
    @(posedge clk) disable iff (!rst_n)
      (cont && (!processorAddrStrobeN || burstStepN)) |=> $stable(cnt_ff);
  endproperty
  a_holdCount: assert property (p_holdCount)
    else $error("burst counter moved without step");

  property p_interleave;
    @(posedge clk) disable iff (!rst_n)
      (cont && interleave && step && cnt_ff == CNT_ZERO)
        |-> curAddr[CNT_W-1:0] == (addr_ff[CNT_W-1:0] ^ CNT_STEP);
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved order wrong");

  property p_linear;
    @(posedge clk) disable iff (!rst_n)
      (cont && !interleave && step && cnt_ff == CNT_ZERO)
        |-> curAddr[CNT_W-1:0] == CNT_W'(addr_ff[CNT_W-1:0] + CNT_STEP);
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear order wrong");

  property p_globalWrite;
    @(posedge clk) disable iff (!rst_n)
      ((startC || cont) && !globalWriteN) |-> wrLanes == LANES_ALL;
  endproperty
  a_globalWrite: assert property (p_globalWrite)
    else $error("global write missed a lane");

  property p_gateOff;
    @(posedge clk) disable iff (!rst_n)
      ((globalWriteN && byteWriteGateN) || startP) |-> wrLanes == LANES_NONE;
  endproperty
  a_gateOff: assert property (p_gateOff)
    else $error("lane written without write command");

  property p_laneWrite;
    @(posedge clk) disable iff (!rst_n)
      ((startC || cont) && globalWriteN && !byteWriteGateN)
        |-> wrLanes == ~laneWriteN;
  endproperty
  a_laneWrite: assert property (p_laneWrite)
    else $error("lane write pattern wrong");

  property p_driverOff;
    @(posedge clk) disable iff (!rst_n)
      !(&laneWriteN) |=> dqOeN_ff;
  endproperty
  a_driverOff: assert property (p_driverOff)
    else $error("pins driven after lane write sampled");

  property p_driveCause;
    @(posedge clk) disable iff (!rst_n)
      !dqOeN_ff |-> $past(oeActive) && outVld_ff;
  endproperty
  a_driveCause: assert property (p_driveCause)
    else $error("pins driven without read or enable");

  property p_ctrlStart;
    @(posedge clk) disable iff (!rst_n)
      (!controllerAddrStrobeN && processorAddrStrobeN && selOk
        && masterSelectN) |=> active_ff;
  endproperty
  a_ctrlStart: assert property (p_ctrlStart)
    else $error("controller start blocked by master select");

  c_burstRead: cover property (@(posedge clk) disable iff (!rst_n)
    startP ##1 step [*3]);
  c_ctrlWrite: cover property (@(posedge clk) disable iff (!rst_n)
    startC && (wrLanes != LANES_NONE));
  c_driven: cover property (@(posedge clk) disable iff (!rst_n)
    readNow ##2 !dqOeN_ff);
  c_deselect: cover property (@(posedge clk) disable iff (!rst_n)
    active_ff && deselect);
endmodule
`default_nettype wire

/* common/pbs_pkg.sv */
/*
  Shared constants for the pipelined burst static memory: array geometry,
  byte lane layout, burst counter width and reset values.
  Assumes nothing of its surroundings; imported whole by every module.
*/
package pbs_pkg;
  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int unsigned ADDR_W = 17;       // Registered address width
  localparam int unsigned WORDS  = 131072;   // Words in the array
  localparam int unsigned LANES  = 4;        // Byte lanes per word
  localparam int unsigned LANE_W = 9;        // Wide variant, parity kept
  localparam int unsigned DATA_W = LANES * LANE_W;
  localparam int unsigned CNT_W  = 2;        // Burst position width

  // ************************************************************
  // Burst and reset values
  // ************************************************************
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 2'h0;
  localparam logic [CNT_W-1:0]  CNT_STEP   = 2'h1;
  localparam logic [LANES-1:0]  LANES_NONE = 4'h0;
  localparam logic [LANES-1:0]  LANES_ALL  = 4'hF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO  = 17'h0_0000;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 36'h0_0000_0000;
endpackage

/* verilog/pbs_store.sv */
/*
  Storage array of the burst memory with per-lane synchronous write and
  combinational read.
  Assumes the caller registers the read data; holds no reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pbs_store
  import pbs_pkg::*;
(
  input  wire logic              clk,     // Memory clock
  input  wire logic [LANES-1:0]  wrLanes, // Lane write strobes, high
  input  wire logic [ADDR_W-1:0] wrAddr,  // Write word address
  input  wire logic [DATA_W-1:0] wrData,  // Write data word
  input  wire logic [ADDR_W-1:0] rdAddr,  // Read word address
  output logic      [DATA_W-1:0] rdData   // Read data word
);
  // ************************************************************
  // Array
  // ************************************************************
  // Each lane owns its own array so partial writes keep the rest and
  // every array has exactly one writing process
  for (genvar g = 0; g < LANES; g++) begin : gLane
    logic [LANE_W-1:0] mem [WORDS];

    always_ff @(posedge clk) begin
      if (wrLanes[g]) begin
        mem[wrAddr] <= wrData[g*LANE_W +: LANE_W];
      end
    end

    // Read is combinational; the caller supplies the pipeline registers
    assign rdData[g*LANE_W +: LANE_W] = mem[rdAddr];
  end
endmodule
`default_nettype wire

/* tb/pbs_bus_model.sv */
/*
  Bus master model for the burst memory: drives the synchronous pins and
  resolves the shared data pins.
  Assumes the bench calls put once per clock; pins change after posedge.
*/
`timescale 1ns/1ps
`default_nettype none
module pbs_bus_model
  import pbs_pkg::*;
(
  input  wire logic              clk,                   // Bus clock
  input  wire logic              oeReq,                 // Read OE wish, low
  input  wire logic [DATA_W-1:0] dqOut,                 // Memory data
  input  wire logic              dqOeN,                 // Memory drive, low
  output logic      [ADDR_W-1:0] addrIn,                // Address
  output logic      [DATA_W-1:0] dqIn,                  // Resolved pins
  output logic                   processorAddrStrobeN,  // Processor strobe
  output logic                   controllerAddrStrobeN, // Controller strobe
  output logic                   burstStepN,            // Burst advance
  output logic                   globalWriteN,          // Write all lanes
  output logic                   byteWriteGateN,        // Lane gate
  output logic      [LANES-1:0]  laneWriteN,            // Lane writes
  output logic                   outputEnableN          // Output enable
);
  logic              drive;  // Master owns the pins
  logic [DATA_W-1:0] wrWord; // Word the master drives
  logic [DATA_W-1:0] lastDq; // Pin value one cycle back

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Applies one cycle of commands; held until the next call
  task automatic apply(input logic [ADDR_W-1:0] a,
                       input logic pN, cN, stN, gwN, gtN,
                       input logic [LANES-1:0] lw,
                       input logic [DATA_W-1:0] d);
    addrIn <= a;
    processorAddrStrobeN <= pN;
    controllerAddrStrobeN <= cN;
    burstStepN <= stN;
    globalWriteN <= gwN;
    byteWriteGateN <= gtN;
    laneWriteN <= lw;
    wrWord <= d;
    // A write command takes the pins, so memory outputs go off
    drive <= !gwN || (!gtN && lw != LANES_ALL);
    outputEnableN <= !gwN || (!gtN && lw != LANES_ALL) || oeReq;
  endtask

  task automatic put(input logic [ADDR_W-1:0] a,
                     input logic pN, cN, stN, gwN, gtN,
                     input logic [LANES-1:0] lw,
                     input logic [DATA_W-1:0] d);
    @(posedge clk);
    apply(a, pN, cN, stN, gwN, gtN, lw, d);
  endtask

  initial begin
    apply(ADDR_ZERO, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, LANES_ALL, DATA_ZERO);
  end

  // Released pins show the inverse of the last value, never a stale copy
  assign dqIn = drive ? wrWord : (!dqOeN ? dqOut : ~lastDq);
  always_ff @(posedge clk) lastDq <= dqIn;
endmodule
`default_nettype wire

/* tb/pipelined_burst_sram_bench.sv */
/*
  Self-checking bench for the burst memory: burst orders, lane writes,
  selects, latency modes and pin drive.
  Assumes pbs_bus_model as bus master and one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_bench
  import pbs_pkg::*;
;
  localparam logic H = 1'b1;
  localparam logic L = 1'b0;
  logic              clk, rst_n, oeReq;                   // Clock, reset
  logic              masterSelectN, selectHi, selectLoN;  // Selects
  logic              countOrderSelect, singleStageSelectN; // Static modes
  logic [ADDR_W-1:0] addrIn;                              // Address
  logic [DATA_W-1:0] dqIn, dqOut;                         // Data pins
  logic              dqOeN, processorAddrStrobeN, controllerAddrStrobeN;
  logic              burstStepN, globalWriteN, byteWriteGateN, outputEnableN;
  logic [LANES-1:0]  laneWriteN;                          // Lane writes
  logic [DATA_W-1:0] refMem [logic [ADDR_W-1:0]];         // Expected words
  int                numErrors, compares;                 // Tallies

  pbs_sram i_dut (.clk, .rst_n, .addrIn, .dqIn, .dqOut, .dqOeN,
    .processorAddrStrobeN, .controllerAddrStrobeN, .burstStepN,
    .globalWriteN, .byteWriteGateN, .laneWriteN, .masterSelectN,
    .selectHi, .selectLoN, .outputEnableN, .countOrderSelect,
    .singleStageSelectN);
  pbs_bus_model i_mst (.clk, .oeReq, .dqOut, .dqOeN, .addrIn, .dqIn,
    .processorAddrStrobeN, .controllerAddrStrobeN, .burstStepN,
    .globalWriteN, .byteWriteGateN, .laneWriteN, .outputEnableN);

  always #5 clk = ~clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [DATA_W-1:0] e, g);
    compares++;
    if (g !== e) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // Burst position n from base b, XOR or linear in the low two bits
  function automatic logic [ADDR_W-1:0] bAddr(input logic [ADDR_W-1:0] b,
                                              input logic [1:0] n,
                                              input logic x);
    return {b[ADDR_W-1:2], x ? b[1:0] ^ n : b[1:0] + n};
  endfunction

  task automatic idle(input int n);
    repeat (n) i_mst.put(ADDR_ZERO, H, H, H, H, H, LANES_ALL, DATA_ZERO);
  endtask

  // Controller-started write burst; take is low when deselected
  task automatic wrB(input logic [ADDR_W-1:0] b, input int n,
                     input logic x, take, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] w;
    for (int i = 0; i < n; i++) begin
      w = d + DATA_W'(i);
      if (take) refMem[bAddr(b, i[1:0], x)] = w;
      i_mst.put(b, H, i != 0, L, L, H, LANES_ALL, w);
    end
    idle(1);
  endtask

  // Processor-started read burst; step is held low on the start edge
  task automatic rdB(input logic [ADDR_W-1:0] b, input int n,
                     input logic x, input int lat, input logic oe);
    int   j;
    logic s;
    for (int i = 0; i < n + lat + 3; i++) begin
      s = i < 2 || i >= n + 2;
      i_mst.put(b, i != 2, H, s, H, H, LANES_ALL, DATA_ZERO);
      #1;
      j = i - lat - 2;
      if (j >= 0 && j < n) begin
        chk("read word", refMem[bAddr(b, j[1:0], x)], dqOut);
        chk("pin drive", DATA_W'(oe), DATA_W'(dqOeN));
      end
    end
    @(posedge clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sXor;
    wrB(17'h0_0012, 4, H, H, 36'h1_0000_0000);
    rdB(17'h0_0012, 4, H, 2, L);
  endtask

  task automatic sLinear;
    countOrderSelect <= L;
    idle(3);
    wrB(17'h1_0001, 4, L, H, 36'h3_0000_0010);
    rdB(17'h1_0001, 4, L, 2, L);
    countOrderSelect <= H;
    idle(3);
  endtask

  // Lanes 0 and 2 written; gated-off and processor-edge lanes ignored
  task automatic sLanes;
    wrB(17'h0_0100, 1, H, H, 36'h9_8765_4321);
    refMem[17'h0_0100] = (refMem[17'h0_0100] & 36'hF_F803_FE00)
                       | (36'h0_ABCD_EF12 & 36'h0_07FC_01FF);
    i_mst.put(17'h0_0100, H, L, H, H, L, 4'hA, 36'h0_ABCD_EF12);
    i_mst.put(17'h0_0100, H, L, H, H, H, 4'h0, 36'h5_5555_5555);
    i_mst.put(17'h0_0100, L, H, H, H, L, 4'h0, 36'h6_6666_6666);
    #1;
    chk("drive off", 36'h0_0000_0001, DATA_W'(dqOeN));
    idle(1);
    #1;
    chk("drive off", 36'h0_0000_0001, DATA_W'(dqOeN));
    rdB(17'h0_0100, 1, H, 2, L);
  endtask

  task automatic sSel;
    masterSelectN <= H;
    wrB(17'h0_0200, 1, H, H, 36'h2_2222_2222);
    // Blocked start keeps the held burst address, so expect its word
    refMem[17'h0_0300] = refMem[17'h0_0200];
    rdB(17'h0_0300, 1, H, 2, L);
    masterSelectN <= L;
    wrB(17'h0_0400, 2, H, H, 36'h4_0000_0000);
    selectHi <= L;
    wrB(17'h0_0400, 2, H, L, 36'h7_0000_0000);
    selectHi <= H;
    selectLoN <= H;
    wrB(17'h0_0400, 2, H, L, 36'h8_0000_0000);
    selectLoN <= L;
    rdB(17'h0_0400, 2, H, 2, L);
  endtask

  task automatic sModes;
    singleStageSelectN <= L;
    rdB(17'h0_0012, 4, H, 1, L);
    singleStageSelectN <= H;
    oeReq <= H;
    rdB(17'h0_0012, 2, H, 2, H);
    oeReq <= L;
  endtask

  task automatic giveVerdict;
    $display("Comparisons %0d, mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Main sequence; every wait is a fixed count of clock edges or a #1 settle delay
  initial begin
    clk = L;
    rst_n = L;
    oeReq = L;
    masterSelectN = L;
    selectHi = H;
    selectLoN = L;
    countOrderSelect = H;
    singleStageSelectN = H;
    numErrors = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    #1;
    chk("reset data", DATA_ZERO, dqOut);
    chk("reset drive", 36'h0_0000_0001, DATA_W'(dqOeN));
    @(posedge clk);
    rst_n <= H;
    idle(3);
    sXor();
    sLinear();
    sLanes();
    sSel();
    sModes();
    giveVerdict();
  end
endmodule
`default_nettype wire
